// [tb/testbench.sv]
/*
 * Self-checking bench for lpm_ctrl: lock, mode entry, gating, wake paths and delays.
 * Assumes the design's package and a single 100 MHz clock; the bench is the bus master.
 */
`timescale 1ns/1ps
module testbench;
    import lpm_pkg::*;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               cyc = 1'b0, stb = 1'b0, wt = 1'b0, irq = 1'b0, isl = 1'b1;
    logic               wdt = 1'b0, swr = 1'b0, pin_n = 1'b1, rcfg = 1'b1, bor = 1'b0;
    logic [2:0]         ipri = 3'h0;
    logic [1:0]         osel = 2'h0;
    lpm_wb_req_type     req = '0;
    logic [31:0]        dat_o, rd;
    logic               ack_o, wclr, drst, por;
    lpm_pwr_type        pwr;
    logic [NPERIPH-1:0] prun;
    int                 n_fail = 0, check_count = 0, cyc_n = 0, nclr = 0, ndr = 0, npor = 0;

    lpm_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_req_i(req), .wb_dat_o(dat_o), .wb_ack_o(ack_o), .wait_exec_i(wt),
        .cpu_prio_i(3'h3), .irq_req_i(irq), .irq_prio_i(ipri), .irq_sleep_src_i(isl),
        .irq_ret_src_i(isl), .osc_sel_i(osel), .wdt_timeout_i(wdt), .sw_reset_i(swr),
        .brownout_i(bor), .external_reset_pin_n_i(pin_n), .retention_regulator_cfg_i(rcfg),
        .pwr_o(pwr), .periph_run_o(prun), .wdt_clear_o(wclr), .dev_reset_req_o(drst),
        .por_req_o(por));

    always #5 clk_i = ~clk_i;

    // Pulse counters and the hang guard
    always @(posedge clk_i) begin
        cyc_n++;
        if (wclr === 1'b1) nclr++;
        if (drst === 1'b1) ndr++;
        if (por === 1'b1) npor++;
        if (cyc_n == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic cycle: request held until ack is sampled, then released for a cycle
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        req <= '{adr: a, dat: d, sel: 4'hf, we: w};
        // No wait limit here: a hang is ended by the cycle guard
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic unlock();
        bus(ADR_UNLOCK, 1'b1, UNLOCK_KEY1);
        bus(ADR_UNLOCK, 1'b1, UNLOCK_KEY2);
    endtask

    task automatic wait_op();
        @(posedge clk_i);
        wt <= 1'b1;
        @(posedge clk_i);
        wt <= 1'b0;
        #1;
    endtask

    // One edge to decide on the wake, then d delay cycles
    task automatic wake_len(input int d);
        int n;
        n = 0;
        @(posedge clk_i);
        irq <= 1'b1;
        ipri <= 3'h5;
        do begin
            settle(1);
            n++;
        end while (pwr.cpu_halt !== 1'b0 && n < 3000);
        @(posedge clk_i);
        irq <= 1'b0;
        chk("wake_len", 32'(d + 1), 32'(n));
    endtask

    // Event 0 other reset, 1 watchdog time-out, 2 brown-out pin
    task automatic pulse_ev(input logic [1:0] ev);
        @(posedge clk_i);
        wdt <= (ev == 2'd1);
        bor <= (ev == 2'd2);
        swr <= (ev == 2'd0);
        @(posedge clk_i);
        wdt <= 1'b0;
        swr <= 1'b0;
        bor <= 1'b0;
        settle(260);
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(5);
        chk("pwr_reset", 32'h79, 32'(pwr));
        chk("prun_reset", 32'h3ff, 32'(prun));
        bus(ADR_OSC_CTRL, 1'b1, 32'h10);
        rchk("osc_locked", ADR_OSC_CTRL, 32'h0);
        unlock();
        rchk("status_unlocked", ADR_STATUS, 32'h30);
        bus(ADR_OSC_CTRL, 1'b1, 32'h10);
        rchk("osc_set", ADR_OSC_CTRL, 32'h10);
        bus(ADR_UNLOCK, 1'b1, WDT_CLR_KEY);
        wait_op();
        chk("pwr_sleep", 32'h89, 32'(pwr));
        chk("prun_sleep", 32'(SLEEP_RUN_MASK), 32'(prun));
        chk("wdt_count_kept", 32'h1, 32'(nclr));
        rchk("status_sleep", ADR_STATUS, 32'h12);
        // A source that is stopped in sleep must not wake the core
        @(posedge clk_i);
        isl <= 1'b0;
        irq <= 1'b1;
        ipri <= 3'h7;
        settle(4);
        chk("sleep_hold", 32'h1, 32'(pwr.cpu_halt & ~pwr.pb_clk_en));
        @(posedge clk_i);
        isl <= 1'b1;
        ipri <= 3'h3;
        settle(3);
        rchk("status_idle", ADR_STATUS, 32'h11);
        chk("idle_clk", 32'h3, {30'h0, pwr.cpu_halt, pwr.pb_clk_en});
        @(posedge clk_i);
        ipri <= 3'h4;
        settle(3);
        @(posedge clk_i);
        irq <= 1'b0;
        rchk("status_run", ADR_STATUS, 32'h10);
        rchk("osc_kept", ADR_OSC_CTRL, 32'h10);
        @(posedge clk_i);
        osel <= 2'h3;
        wait_op();
        wake_len(100);
        bus(ADR_PWR_CTRL, 1'b1, 32'h1);
        @(posedge clk_i);
        osel <= 2'h0;
        wait_op();
        chk("pwr_standby", 32'h8d, 32'(pwr));
        chk("prun_standby", 32'(SLEEP_RUN_MASK), 32'(prun));
        wake_len(202);
        rchk("pwr_kept", ADR_PWR_CTRL, 32'h1);
        wait_op();
        pulse_ev(2'd1);
        chk("wdt_wake", 32'h0, 32'(pwr.cpu_halt));
        wait_op();
        pulse_ev(2'd0);
        chk("rst_wake", 32'h1, 32'(!pwr.cpu_halt && ndr == 1));
        wait_op();
        pulse_ev(2'd2);
        chk("bor_reset", 32'h2, 32'(ndr));
        chk("bor_wake", 32'h0, 32'(pwr.cpu_halt));
        bus(ADR_PWR_CTRL, 1'b1, 32'h0);
        unlock();
        bus(ADR_OSC_CTRL, 1'b1, 32'h0);
        bus(ADR_IDLE_STOP, 1'b1, 32'hc0);
        wait_op();
        chk("prun_idle", 32'h33f, 32'(prun));
        chk("idle_run", 32'h3, {30'h0, pwr.cpu_halt, pwr.pb_clk_en});
        pulse_ev(2'd1);
        chk("idle_wdt_exit", 32'h0, 32'(pwr.cpu_halt));
        // Second reset with the retention regulator selected
        @(posedge clk_i);
        rst_i <= 1'b1;
        rcfg <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(5);
        rchk("status_cfg", ADR_STATUS, 32'h0);
        bus(ADR_PWR_CTRL, 1'b1, 32'h3);
        unlock();
        bus(ADR_OSC_CTRL, 1'b1, 32'h10);
        wait_op();
        rchk("status_ret", ADR_STATUS, 32'ha);
        chk("prun_ret", 32'(RET_RUN_MASK), 32'(prun));
        chk("ret_reg", 32'h1, 32'(pwr.ret_reg_en));
        @(posedge clk_i);
        pin_n <= 1'b0;
        settle(8);
        @(posedge clk_i);
        pin_n <= 1'b1;
        chk("por_req", 32'h1, 32'(npor > 0));
        final_report();
    end
endmodule

// [verilog/lpm_ctrl.sv]
/*
 * Low-power mode sequencer: Idle, Sleep, Standby Sleep and Retention Sleep,
 * wake-up decision and delay, clock and peripheral gating, lock-protected sleep enable bit.
 * Assumes a classic Wishbone master, a one-cycle wait pulse from the CPU and
 * interrupt requests already filtered by their enable bits.
 */
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module lpm_ctrl
    import lpm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    // Register bus
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire lpm_wb_req_type       wb_req_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // CPU side
    input  wire logic                 wait_exec_i,
    input  wire logic [2:0]           cpu_prio_i,
    input  wire logic                 irq_req_i,
    input  wire logic [2:0]           irq_prio_i,
    input  wire logic                 irq_sleep_src_i,
    input  wire logic                 irq_ret_src_i,
    input  wire logic [1:0]           osc_sel_i,
    // Reset and watchdog events
    input  wire logic                 wdt_timeout_i,
    input  wire logic                 sw_reset_i,
    input  wire logic                 brownout_i,
    input  wire logic                 external_reset_pin_n_i,
    input  wire logic                 retention_regulator_cfg_i,
    // Power, clock and peripheral control
    output lpm_pwr_type               pwr_o,
    output logic [NPERIPH-1:0]        periph_run_o,
    output logic                      wdt_clear_o,
    output logic                      dev_reset_req_o,
    output logic                      por_req_o
);

    lpm_state_type        state_reg;
    lpm_state_type        state_next;
    lpm_kind_type         kind_reg;
    lpm_kind_type         kind_next;
    logic                 sleep_enable_bit_reg;
    logic                 regulator_standby_bit_reg;
    logic                 retention_enable_bit_reg;
    logic [NPERIPH-1:0]   stop_in_idle_reg;
    logic [1:0]           unlock_stage_reg;
    logic                 ret_cfg_reg;
    logic [2:0]           cfg_valid_reg;
    logic [15:0]          wake_cnt_reg;
    logic [15:0]          wake_load;
    logic [1:0]           bor_sync_reg;
    logic [1:0]           xrst_sync_reg;
    logic [1:0]           cfg_sync_reg;
    logic                 wb_ack_reg;
    logic [31:0]          wb_dat_reg;
    logic                 wdt_clear_reg;
    logic                 dev_reset_reg;
    logic                 por_reg;
    logic                 bus_req;
    logic                 bus_wr;
    logic                 unlocked;
    logic                 reset_evt;
    logic                 xrst_evt;
    logic                 irq_wake_src;
    logic                 irq_above;

    assign unlocked  = (unlock_stage_reg == 2'd2);
    assign bus_req   = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where the master sees ack, never earlier
    assign bus_wr    = bus_req & wb_ack_reg & wb_req_i.we;
    assign xrst_evt  = xrst_sync_reg[1];
    assign reset_evt = bor_sync_reg[1] | xrst_evt | sw_reset_i;
    assign irq_above = (irq_prio_i > cpu_prio_i);
    assign irq_wake_src = irq_req_i &
        ((kind_reg == SK_RETENTION) ? irq_ret_src_i : irq_sleep_src_i);

    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bor_sync_reg  <= 2'b00;
            xrst_sync_reg <= 2'b00;
            cfg_sync_reg  <= 2'b11;
        end else if (ce_i) begin
            bor_sync_reg  <= {bor_sync_reg[0], brownout_i};
            xrst_sync_reg <= {xrst_sync_reg[0], ~external_reset_pin_n_i};
            cfg_sync_reg  <= {cfg_sync_reg[0], retention_regulator_cfg_i};
        end
    end

    // Config bit is held only once the synchroniser has refilled from the pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ret_cfg_reg   <= 1'b1;
            cfg_valid_reg <= 3'b000;
        end else if (ce_i && !cfg_valid_reg[2]) begin
            ret_cfg_reg   <= cfg_sync_reg[1];
            cfg_valid_reg <= {cfg_valid_reg[1:0], 1'b1};
        end
    end

    // Bus acknowledge: one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_reg <= 1'b0;
        end else if (ce_i) begin
            wb_ack_reg <= bus_req & ~wb_ack_reg;
        end
    end

    // Read data; unmapped offsets read as zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_reg <= 32'h0000_0000;
        end else if (ce_i && bus_req && !wb_ack_reg) begin
            wb_dat_reg <= 32'h0000_0000;
            unique case (wb_req_i.adr)
                ADR_OSC_CTRL: begin
                    wb_dat_reg[SLEEP_EN_POS] <= sleep_enable_bit_reg;
                end
                ADR_PWR_CTRL: begin
                    wb_dat_reg[VREG_STBY_POS] <= regulator_standby_bit_reg;
                    wb_dat_reg[RET_EN_POS]    <= retention_enable_bit_reg;
                end
                ADR_UNLOCK: begin
                    wb_dat_reg[1:0] <= unlock_stage_reg;
                end
                ADR_IDLE_STOP: begin
                    wb_dat_reg[NPERIPH-1:0] <= stop_in_idle_reg;
                end
                ADR_STATUS: begin
                    wb_dat_reg[1:0]         <= 2'(state_reg);
                    wb_dat_reg[3:2]         <= 2'(kind_reg);
                    wb_dat_reg[4]           <= ret_cfg_reg;
                    wb_dat_reg[5]           <= unlocked;
                end
                default: begin
                    wb_dat_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Unlock sequence: two keys in a row open one protected write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unlock_stage_reg <= 2'd0;
        end else if (ce_i && bus_wr) begin
            if (wb_req_i.adr == ADR_UNLOCK) begin
                if (wb_req_i.dat == UNLOCK_KEY1) begin
                    unlock_stage_reg <= 2'd1;
                end else if (wb_req_i.dat == UNLOCK_KEY2 && unlock_stage_reg == 2'd1) begin
                    unlock_stage_reg <= 2'd2;
                end else begin
                    unlock_stage_reg <= 2'd0;
                end
            end else if (wb_req_i.adr == ADR_OSC_CTRL) begin
                unlock_stage_reg <= 2'd0;
            end
        end
    end

    // Sleep enable: only a write while unlocked changes it; wake leaves it alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_enable_bit_reg <= 1'b0;
        end else if (ce_i && bus_wr && wb_req_i.adr == ADR_OSC_CTRL && unlocked) begin
            sleep_enable_bit_reg <= wb_req_i.dat[SLEEP_EN_POS];
        end
    end

    // Power control and stop-in-idle bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regulator_standby_bit_reg <= 1'b0;
            retention_enable_bit_reg  <= 1'b0;
            stop_in_idle_reg          <= IDLE_STOP_RST;
        end else if (ce_i && bus_wr) begin
            if (wb_req_i.adr == ADR_PWR_CTRL) begin
                regulator_standby_bit_reg <= wb_req_i.dat[VREG_STBY_POS];
                retention_enable_bit_reg  <= wb_req_i.dat[RET_EN_POS];
            end
            if (wb_req_i.adr == ADR_IDLE_STOP) begin
                stop_in_idle_reg <= wb_req_i.dat[NPERIPH-1:0];
            end
        end
    end

    // Watchdog clear only by software key; sleep entry never pulses it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_clear_reg <= 1'b0;
        end else if (ce_i) begin
            wdt_clear_reg <= bus_wr && wb_req_i.adr == ADR_UNLOCK &&
                             wb_req_i.dat == WDT_CLR_KEY;
        end
    end

    // Reset requests; brown-out is honoured in every state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dev_reset_reg <= 1'b0;
            por_reg       <= 1'b0;
        end else if (ce_i) begin
            dev_reset_reg <= reset_evt;
            por_reg       <= xrst_evt && state_reg == ST_SLEEP && kind_reg == SK_RETENTION;
        end
    end

    // Wake delay grows with oscillator choice and regulator depth
    always_comb begin
        unique case (osc_sel_i)
            2'd0: wake_load = WAKE_OSC0_CYC;
            2'd1: wake_load = WAKE_OSC1_CYC;
            2'd2: wake_load = WAKE_OSC2_CYC;
            2'd3: wake_load = WAKE_OSC3_CYC;
        endcase
        if (kind_reg == SK_STANDBY) begin
            wake_load = wake_load + WAKE_STBY_CYC;
        end else if (kind_reg == SK_RETENTION) begin
            wake_load = wake_load + WAKE_RET_CYC;
        end
    end

    // Mode sequencer
    always_comb begin
        state_next = state_reg;
        kind_next  = kind_reg;
        unique case (state_reg)
            ST_RUN: begin
                if (wait_exec_i) begin
                    if (sleep_enable_bit_reg) begin
                        state_next = ST_SLEEP;
                        if (retention_enable_bit_reg && !ret_cfg_reg) begin
                            kind_next = SK_RETENTION;
                        end else if (regulator_standby_bit_reg) begin
                            kind_next = SK_STANDBY;
                        end else begin
                            kind_next = SK_SLEEP;
                        end
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_SLEEP: begin
                if (reset_evt || wdt_timeout_i) begin
                    state_next = ST_WAKE;
                end else if (irq_wake_src) begin
                    state_next = irq_above ? ST_WAKE : ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (reset_evt || wdt_timeout_i || (irq_req_i && irq_above)) begin
                    state_next = ST_RUN;
                end
            end
            ST_WAKE: begin
                if (wake_cnt_reg <= 16'd1) begin
                    state_next = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_RUN;
            kind_reg  <= SK_SLEEP;
        end else if (ce_i) begin
            state_reg <= state_next;
            kind_reg  <= kind_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_cnt_reg <= 16'd0;
        end else if (ce_i) begin
            if (state_reg == ST_SLEEP && state_next == ST_WAKE) begin
                wake_cnt_reg <= wake_load;
            end else if (state_reg == ST_WAKE) begin
                wake_cnt_reg <= wake_cnt_reg - 16'd1;
            end
        end
    end

    // Clock and regulator controls
    always_comb begin
        pwr_o              = '0;
        pwr_o.cpu_halt     = (state_reg != ST_RUN);
        pwr_o.cpu_clk_en   = (state_reg == ST_RUN);
        pwr_o.pb_clk_en    = (state_reg == ST_RUN) || (state_reg == ST_IDLE);
        // Monitor would flag stopped clocks as a failure, so it rests in sleep
        pwr_o.clk_monitor_en = (state_reg == ST_RUN) || (state_reg == ST_IDLE);
        pwr_o.bor_en       = 1'b1;
        pwr_o.vreg_standby = (state_reg == ST_SLEEP) && (kind_reg == SK_STANDBY);
        pwr_o.ret_reg_en   = (state_reg == ST_SLEEP) && (kind_reg == SK_RETENTION);
        pwr_o.pins_drive   = 1'b1;
    end

    // Peripheral run enables per mode
    always_comb begin
        unique case (state_reg)
            ST_RUN:  periph_run_o = '1;
            ST_IDLE: periph_run_o = ~stop_in_idle_reg;
            default: begin
                periph_run_o = (kind_reg == SK_RETENTION) ? RET_RUN_MASK
                                                          : SLEEP_RUN_MASK;
            end
        endcase
    end

    assign wb_ack_o        = wb_ack_reg;
    assign wb_dat_o        = wb_dat_reg;
    assign wdt_clear_o     = wdt_clear_reg;
    assign dev_reset_req_o = dev_reset_reg;
    assign por_req_o       = por_reg;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence wait_with_sleep_s;
        state_reg == ST_RUN && ce_i && wait_exec_i && sleep_enable_bit_reg;
    endsequence

    sequence sleep_quiet_s;
        state_reg == ST_SLEEP && ce_i && !reset_evt && !wdt_timeout_i && irq_wake_src;
    endsequence

    sleep_entry_a: assert property (wait_with_sleep_s |=> state_reg == ST_SLEEP
        && pwr_o.cpu_halt && !pwr_o.cpu_clk_en && !pwr_o.pb_clk_en)
        else $error("sleep not entered on wait");
    monitor_sleep_a: assert property (state_reg == ST_SLEEP |-> !pwr_o.clk_monitor_en)
        else $error("clock monitor active in sleep");
    bor_live_a: assert property (bor_sync_reg[1] && ce_i |=> dev_reset_req_o)
        else $error("brown-out lost");
    wdt_keep_a: assert property (wait_with_sleep_s |=> !wdt_clear_o)
        else $error("watchdog cleared on sleep entry");
    irq_wake_a: assert property (sleep_quiet_s and irq_above |=> state_reg == ST_WAKE)
        else $error("high priority interrupt did not wake");
    reset_wake_a: assert property (state_reg == ST_SLEEP && ce_i
        && (reset_evt || wdt_timeout_i) |=> state_reg == ST_WAKE)
        else $error("reset or time-out did not wake");
    low_prio_idle_a: assert property (sleep_quiet_s and !irq_above
        |=> state_reg == ST_IDLE && pwr_o.pb_clk_en && pwr_o.cpu_halt)
        else $error("low priority wake not idle");
    lock_block_a: assert property (bus_wr && ce_i && wb_req_i.adr == ADR_OSC_CTRL
        && !unlocked |=> $stable(sleep_enable_bit_reg))
        else $error("locked sleep enable changed");
    standby_reg_a: assert property (wait_with_sleep_s and regulator_standby_bit_reg
        && !(retention_enable_bit_reg && !ret_cfg_reg) |=> pwr_o.vreg_standby)
        else $error("regulator standby missing");
    retention_a: assert property (wait_with_sleep_s and retention_enable_bit_reg
        && !ret_cfg_reg |=> pwr_o.ret_reg_en && periph_run_o == RET_RUN_MASK)
        else $error("retention sleep wrong");
    por_wake_a: assert property (xrst_evt && ce_i && state_reg == ST_SLEEP
        && kind_reg == SK_RETENTION |=> por_req_o)
        else $error("no power-on reset from retention");
    wake_delay_a: assert property (state_reg == ST_WAKE && ce_i
        && wake_cnt_reg > 16'd1 |=> state_reg == ST_WAKE && pwr_o.cpu_halt)
        else $error("wake delay cut short");
    idle_entry_a: assert property (state_reg == ST_RUN && ce_i && wait_exec_i
        && !sleep_enable_bit_reg |=> state_reg == ST_IDLE && pwr_o.pb_clk_en)
        else $error("idle not entered");
    mode_keep_a: assert property (state_reg == ST_WAKE && ce_i
        |=> $stable(sleep_enable_bit_reg) && $stable(retention_enable_bit_reg))
        else $error("mode bit changed by wake");

endmodule

// [verilog/lpm_pkg.sv]
/*
 * Constants, types and register map of the low-power mode sequencer.
 * Assumes a 100 MHz system clock and a classic Wishbone master on the register side.
 */
// What this block does
// - Wait with sleep enable set enters Sleep; CPU and peripheral bus clocks stop.
// - Fail-safe clock monitor is off for the whole Sleep period.
// - Brown-out detection stays enabled in Sleep and can still reset the device.
// - Sleep entry never clears the watchdog count.
// - Enabled sleep-capable interrupt above CPU priority wakes the device.
// - Any device reset and a watchdog time-out wake the device from Sleep.
// - Waking interrupt at or below CPU priority restarts bus clock, CPU halted (Idle).
// - Sleep enable changes only after the unlock sequence; other writes are blocked.
// - Regulator standby bit set puts regulator in standby during Sleep unless Retention Sleep is chosen, longer wake.
// - Everything that runs in Sleep also runs in Standby Sleep.
// - Retention Sleep when retention cfg bit clear and retention enable set.
// - Retention Sleep keeps only first timer, watchdog, calendar and reference clock.
// - External reset pin waking from Retention Sleep gives a power-on reset.
// - Sleep keeps pin change, watchdog, converter, serial and low-power clocked units.
// - Output pins keep driving their levels during Sleep.
// - Wake-up to Run inserts a delay set by the selected oscillator and regulator depth before execution; wake to Idle has no delay.
// - Wait with sleep enable clear enters Idle; CPU halts, peripheral clocks keep running.
// - In Idle, peripherals with stop-in-idle set halt, the others keep running.
package lpm_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // Register byte offsets
    localparam logic [4:0] ADR_OSC_CTRL  = 5'h00;
    localparam logic [4:0] ADR_PWR_CTRL  = 5'h04;
    localparam logic [4:0] ADR_UNLOCK    = 5'h08;
    localparam logic [4:0] ADR_IDLE_STOP = 5'h0c;
    localparam logic [4:0] ADR_STATUS    = 5'h10;

    // Field positions
    localparam int SLEEP_EN_POS  = 4;
    localparam int VREG_STBY_POS = 0;
    localparam int RET_EN_POS    = 1;
    localparam int RET_CFG_POS   = 2;

    // Unlock and watchdog-clear keys
    localparam logic [31:0] UNLOCK_KEY1  = 32'h0f0f_a5a5;
    localparam logic [31:0] UNLOCK_KEY2  = 32'h5a5a_f0f0;
    localparam logic [31:0] WDT_CLR_KEY  = 32'h0000_c1ea;

    // Reset values
    localparam logic [9:0] IDLE_STOP_RST = 10'h000;

    // Peripheral slots: 0 first timer, 1 watchdog, 2 calendar, 3 reference clock,
    // 4 pin change, 5 converter, 6 serial port, 7 external/low-power clocked, 8-9 others
    localparam int NPERIPH = 10;
    localparam logic [9:0] SLEEP_RUN_MASK = 10'h0ff;
    localparam logic [9:0] RET_RUN_MASK   = 10'h00f;

    // Wake-up times and their cycle counts (least times, rounded up)
    localparam int WAKE_OSC0_NS  = 20;
    localparam int WAKE_OSC1_NS  = 100;
    localparam int WAKE_OSC2_NS  = 500;
    localparam int WAKE_OSC3_NS  = 1000;
    localparam int WAKE_STBY_NS  = 2000;
    localparam int WAKE_RET_NS   = 10000;
    localparam logic [15:0] WAKE_OSC0_CYC = 16'((WAKE_OSC0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] WAKE_OSC1_CYC = 16'((WAKE_OSC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] WAKE_OSC2_CYC = 16'((WAKE_OSC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] WAKE_OSC3_CYC = 16'((WAKE_OSC3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] WAKE_STBY_CYC = 16'((WAKE_STBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] WAKE_RET_CYC  = 16'((WAKE_RET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum {ST_RUN, ST_IDLE, ST_SLEEP, ST_WAKE} lpm_state_type;
    typedef enum {SK_SLEEP, SK_STANDBY, SK_RETENTION} lpm_kind_type;

    typedef struct packed {
        logic [4:0]  adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
    } lpm_wb_req_type;

    typedef struct packed {
        logic cpu_halt;
        logic cpu_clk_en;
        logic pb_clk_en;
        logic clk_monitor_en;
        logic bor_en;
        logic vreg_standby;
        logic ret_reg_en;
        logic pins_drive;
    } lpm_pwr_type;

endpackage
